/* hdl/serial_port_map.vh */
/*
  Register map, field positions, reset values and timing counts for the
  asynchronous serial port. Assumes an 8-bit register port with a
  3-bit address and a 16x oversampling baud tick.
*/
// Overview of operation
// [RULE1] 8 or 9 data bits, full duplex, transmitter and receiver enabled apart
// [RULE2] Even, odd, mark, space or no parity, checked on reception
// [RULE3] One or two stop bits per frame
// [RULE4] Bit rate from a 16-bit divider built from high and low bytes
// [RULE5] Receive queue holds up to four characters
// [RULE6] Transmit holds one pending character beside the one shifting
// [RULE7] With address detect on, received last data bit one interrupts
// [RULE8] Interrupts for tx empty, tx idle, rx available, overrun, address
// [RULE9] Port plus tx enable drives the tx pin, pull-up off
// [RULE10] Port or tx or rx enable clear leaves the pin floating; the code floats it on port or tx enable clear only
// [RULE11] Written character moves to shifter, sent LSB first at baud rate
// [RULE12] Bits shift in LSB first, full character goes to receive buffer
// [RULE13] One data address: write transmits, read returns oldest character
// [RULE14] Status read only; idle and tx empty read one after reset
// [RULE15] Parity error flag bit 7, cleared by status read then data access
// [RULE16] Noise flag bit 6, set with data, never for overrun
// [RULE17] Framing error flag bit 5, same clear sequence
// [RULE18] Overrun flag bit 4 blocks further receive, same clear sequence
// [RULE19] Receiver idle bit 3 low from start bit until stop bit
// [RULE20] Receive available bit 2 set at trigger level, may interrupt
// [RULE21] Error flags set in the cycle the word enters the buffer
// [RULE22] Software clears rx available by status read then data read
// [RULE23] Transmitter idle when buffer empty and nothing sending, line high
// [RULE24] Port disable flushes, resets baud, clears flags and enables
// [RULE25] Parity type 00 even, 01 odd, 10 mark, 11 space
// [RULE26] Length select 0 is 8 bits, 1 is 9 bits, ninth bits apart
// [RULE27] Three samples at bit centre, majority wins, disagreement is noise
// [RULE28] Trigger level one to four characters, count register reports fill
`ifndef SERIAL_PORT_MAP_VH
`define SERIAL_PORT_MAP_VH
// ========================================
// Register offsets
`define OFF_STATUS 3'h0
`define OFF_CTL_ONE 3'h1
`define OFF_CTL_TWO 3'h2
`define OFF_DATA 3'h3
`define OFF_BAUD_HIGH 3'h4
`define OFF_BAUD_LOW 3'h5
`define OFF_FIFO_CTL 3'h6
`define OFF_RX_COUNT 3'h7
// ========================================
// Control field positions
`define C1_PORT_EN 7
`define C1_LEN 6
`define C1_PAR_EN 5
`define C1_BREAK 2
`define C1_TX8 0
`define C2_TX_EN 7
`define C2_RX_EN 6
`define C2_STOP 5
`define C2_ADDR_EN 4
`define C2_RX_IE 2
`define C2_TIDLE_IE 1
`define C2_TEMPTY_IE 0
// ========================================
// Reset values
`define STATUS_RST 8'h0B
`define CTL_RST 8'h00
// ========================================
// Timing counts in oversample ticks and bit times
`define TICK_LAST 4'hF
`define SAMPLE_A 4'h7
`define SAMPLE_B 4'h8
`define SAMPLE_C 4'h9
`define BREAK_BITS 4'hD
`endif

/* hdl/async_serial_port.v */
/*
  Asynchronous serial port: register port, baud generator, transmitter
  with one pending character, receiver with a four-entry queue.
  Assumes a single clock; the receive pin is asynchronous to it.
*/
// The plain strobed port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`include "serial_port_map.vh"

module async_serial_port #(
  parameter FIFO_DEPTH = 4
) (
  input wire clock_in,
  input wire reset_n_in,
  input wire [2:0] addr_in,
  input wire [7:0] wr_data_in,
  input wire wr_in,
  input wire rd_in,
  output reg [7:0] rd_data_out,
  input wire serial_in_pin_in,
  output reg serial_out_pin_out,
  output reg serial_out_pin_oe_n_out,
  output reg tx_pullup_en_out,
  output reg irq_out
);

  // ========================================
  // Parity over the bits below the parity position
  function par_bit;
    input [8:0] w;
    input [1:0] typ;
    input nine;
    reg x;
    begin
      x = nine ? ^w[7:0] : ^w[6:0];
      // [RULE25] even, odd, mark, space
      case (typ)
        2'b00: par_bit = x;
        2'b01: par_bit = ~x;
        2'b10: par_bit = 1'b1;
        default: par_bit = 1'b0;
      endcase
    end
  endfunction

  // ========================================
  // Register state
  reg en_q, bno_q, pren_q, brk_q, tx8_q;
  reg [1:0] prt_q;
  reg [7:0] ctl2_q, bdh_q, bdl_q;
  reg [5:0] fcr_q;
  reg seq_q;
  wire wr_data = wr_in && addr_in == `OFF_DATA;
  wire rd_data = rd_in && addr_in == `OFF_DATA;
  // [RULE1] transmitter and receiver enabled apart
  wire txon = en_q && ctl2_q[`C2_TX_EN];
  wire rxon = en_q && ctl2_q[`C2_RX_EN];

  // Control writes; enables drop whenever the port is off
  always @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      en_q <= 1'b0;
      bno_q <= 1'b0;
      pren_q <= 1'b0;
      prt_q <= 2'b00;
      brk_q <= 1'b0;
      tx8_q <= 1'b0;
      ctl2_q <= `CTL_RST;
      bdh_q <= `CTL_RST;
      bdl_q <= `CTL_RST;
      fcr_q <= 6'h00;
    end else begin
      if (wr_in && addr_in == `OFF_CTL_ONE) begin
        en_q <= wr_data_in[`C1_PORT_EN];
        bno_q <= wr_data_in[`C1_LEN];
        pren_q <= wr_data_in[`C1_PAR_EN];
        prt_q <= wr_data_in[4:3];
        brk_q <= wr_data_in[`C1_BREAK];
        tx8_q <= wr_data_in[`C1_TX8];
      end
      if (wr_in && addr_in == `OFF_CTL_TWO)
        ctl2_q <= wr_data_in;
      if (wr_in && addr_in == `OFF_BAUD_HIGH)
        bdh_q <= wr_data_in;
      if (wr_in && addr_in == `OFF_BAUD_LOW)
        bdl_q <= wr_data_in;
      if (wr_in && addr_in == `OFF_FIFO_CTL)
        fcr_q <= wr_data_in[5:0];
      // [RULE24] disable clears enables
      if (!en_q) begin
        ctl2_q[7:6] <= 2'b00;
        brk_q <= 1'b0;
      end
    end
  end

  // ========================================
  // Baud generator, one tick per divider+1 clocks, 16 ticks a bit
  reg [15:0] bcnt_q;
  // [RULE4] 16-bit divider
  wire tick = en_q && bcnt_q == {bdh_q, bdl_q};
  always @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in)
      bcnt_q <= 16'h0000;
    else if (!en_q || tick)
      bcnt_q <= 16'h0000;
    else
      bcnt_q <= bcnt_q + 16'h0001;
  end

  // ========================================
  // Transmitter
  reg [8:0] tbuf_q;
  reg tfull_q, tbusy_q, tbrk_q;
  reg [11:0] tsh_q;
  reg [3:0] tph_q, tbits_q;
  reg [8:0] tw;
  reg [3:0] tlen;
  // Frame image: start bit, data with parity folded in, stop ones
  always @* begin
    tw = tbuf_q;
    // [RULE2] parity replaces last data bit
    if (pren_q && bno_q)
      tw[8] = par_bit(tbuf_q, prt_q, 1'b1);
    if (pren_q && !bno_q)
      tw[7] = par_bit(tbuf_q, prt_q, 1'b0);
    if (!bno_q)
      tw[8] = 1'b1;
    // [RULE3] one or two stop bits
    tlen = (bno_q ? 4'hB : 4'hA) + {3'b000, ctl2_q[`C2_STOP]};
  end
  wire tidle = !tfull_q && !tbusy_q && !tbrk_q;

  always @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tbuf_q <= 9'h000;
      tfull_q <= 1'b0;
      tbusy_q <= 1'b0;
      tbrk_q <= 1'b0;
      tsh_q <= 12'hFFF;
      tph_q <= 4'h0;
      tbits_q <= 4'h0;
    end else if (!txon) begin
      // [RULE24] abort and flush
      tfull_q <= 1'b0;
      tbusy_q <= 1'b0;
      tbrk_q <= 1'b0;
      tsh_q <= 12'hFFF;
    end else begin
      // [RULE6] single pending slot
      if (wr_data) begin
        tbuf_q <= {tx8_q, wr_data_in};
        tfull_q <= 1'b1;
      end
      if (!tbusy_q && !tbrk_q) begin
        if (tfull_q) begin
          // [RULE11] load shifter
          tsh_q <= {2'b11, tw, 1'b0};
          tbits_q <= tlen;
          tbusy_q <= 1'b1;
          tph_q <= 4'h0;
          if (!wr_data)
            tfull_q <= 1'b0;
        end else if (brk_q) begin
          tbrk_q <= 1'b1;
          tbits_q <= `BREAK_BITS;
          tph_q <= 4'h0;
        end
      end else if (tick) begin
        tph_q <= tph_q + 4'h1;
        if (tph_q == `TICK_LAST) begin
          if (tbusy_q) begin
            // [RULE11] LSB first
            tsh_q <= {1'b1, tsh_q[11:1]};
            tbits_q <= tbits_q - 4'h1;
            if (tbits_q == 4'h1)
              tbusy_q <= 1'b0;
          end else begin
            // Break lasts 13 bits at least, then until released
            if (tbits_q != 4'h0)
              tbits_q <= tbits_q - 4'h1;
            if (tbits_q <= 4'h1 && !brk_q)
              tbrk_q <= 1'b0;
          end
        end
      end
    end
  end

  // ========================================
  // Receive pin synchroniser; a change counts once stages 2 and 3 agree
  reg s1_q, s2_q, s3_q, rxf_q, rlast_q;
  always @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      rxf_q <= 1'b1;
      rlast_q <= 1'b1;
    end else begin
      s1_q <= serial_in_pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q)
        rxf_q <= s3_q;
      rlast_q <= rxf_q;
    end
  end

  // ========================================
  // Receiver
  reg rbusy_q, rnz_q, rfe_q, push_q;
  reg [3:0] rph_q, rbit_q;
  reg [1:0] smp_q;
  reg [8:0] rsh_q;
  wire [3:0] nd = bno_q ? 4'h9 : 4'h8;
  wire [3:0] rlast = nd + (ctl2_q[`C2_STOP] ? 4'h2 : 4'h1);
  // [RULE27] majority of three, disagreement is noise
  wire vote = (smp_q[1] & smp_q[0]) | (smp_q[1] & rxf_q) | (smp_q[0] & rxf_q);
  wire nz = !(smp_q[1] == smp_q[0] && smp_q[0] == rxf_q);
  wire bitmid = rbusy_q && tick && rph_q == `SAMPLE_C;

  always @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rbusy_q <= 1'b0;
      rnz_q <= 1'b0;
      rfe_q <= 1'b0;
      push_q <= 1'b0;
      rph_q <= 4'h0;
      rbit_q <= 4'h0;
      smp_q <= 2'b11;
      rsh_q <= 9'h000;
    end else begin
      push_q <= 1'b0;
      if (!rxon) begin
        rbusy_q <= 1'b0;
      end else if (!rbusy_q) begin
        // [RULE19] start bit ends idle
        if (rlast_q && !rxf_q) begin
          rbusy_q <= 1'b1;
          rph_q <= 4'h0;
          rbit_q <= 4'h0;
          rnz_q <= 1'b0;
          rfe_q <= 1'b0;
        end
      end else if (tick) begin
        rph_q <= rph_q + 4'h1;
        if (rph_q == `SAMPLE_A || rph_q == `SAMPLE_B)
          smp_q <= {smp_q[0], rxf_q};
        if (bitmid) begin
          rbit_q <= rbit_q + 4'h1;
          rnz_q <= rnz_q | nz;
          if (rbit_q == 4'h0 && vote)
            rbusy_q <= 1'b0;
          // [RULE12] shift in LSB first
          if (rbit_q != 4'h0 && rbit_q <= nd)
            rsh_q <= {vote, rsh_q[8:1]};
          if (rbit_q > nd && !vote)
            rfe_q <= 1'b1;
          if (rbit_q == rlast) begin
            rbusy_q <= 1'b0;
            push_q <= 1'b1;
          end
        end
      end
    end
  end

  // Assembled word and its error bits
  // [RULE26] eight or nine bits, parity bit kept out of the data
  wire [8:0] d9 = bno_q ? rsh_q : {1'b0, rsh_q[8:1]};
  wire lastbit = bno_q ? d9[8] : d9[7];
  wire [8:0] dkeep = pren_q ? (bno_q ? {1'b0, d9[7:0]} : {2'b00, d9[6:0]}) : d9;
  // [RULE2] check received parity
  wire perr = pren_q && par_bit(d9, prt_q, bno_q) != lastbit;
  wire [11:0] entry = {rnz_q, rfe_q, perr, dkeep};

  // ========================================
  // Receive queue and status flags
  reg [11:0] mem_q [0:FIFO_DEPTH-1];
  reg [1:0] wp_q, rp_q;
  reg [2:0] cnt_q;
  reg pe_q, nf_q, fe_q, oe_q, rxif_q, ahit_q;
  // [RULE18] overrun blocks entry
  wire do_push = push_q && !oe_q && cnt_q != FIFO_DEPTH;
  wire do_ovr = push_q && !oe_q && cnt_q == FIFO_DEPTH;
  // [RULE13] read pops oldest
  wire do_pop = rd_data && cnt_q != 3'h0;
  wire [2:0] cnt_n = cnt_q + {2'b00, do_push} - {2'b00, do_pop};
  // [RULE28] trigger level one to four
  wire [2:0] trig = {1'b0, fcr_q[1:0]} + 3'h1;
  wire clr = seq_q && (rd_data || wr_data);
  wire [11:0] head = mem_q[rp_q];

  always @(posedge clock_in) begin
    if (do_push)
      mem_q[wp_q] <= entry;
  end

  always @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wp_q <= 2'b00;
      rp_q <= 2'b00;
      cnt_q <= 3'h0;
      pe_q <= 1'b0;
      nf_q <= 1'b0;
      fe_q <= 1'b0;
      oe_q <= 1'b0;
      rxif_q <= 1'b0;
      ahit_q <= 1'b0;
      seq_q <= 1'b0;
    end else if (!en_q) begin
      // [RULE24] flush and clear flags
      wp_q <= 2'b00;
      rp_q <= 2'b00;
      cnt_q <= 3'h0;
      pe_q <= 1'b0;
      nf_q <= 1'b0;
      fe_q <= 1'b0;
      oe_q <= 1'b0;
      rxif_q <= 1'b0;
      ahit_q <= 1'b0;
      seq_q <= 1'b0;
    end else begin
      // [RULE5] four-entry queue
      if (do_push)
        wp_q <= wp_q + 2'b01;
      if (do_pop)
        rp_q <= rp_q + 2'b01;
      cnt_q <= cnt_n;
      // Status read arms the clear; a data access consumes it
      if (rd_in && addr_in == `OFF_STATUS)
        seq_q <= 1'b1;
      else if (rd_data || wr_data)
        seq_q <= 1'b0;
      // [RULE15] [RULE21] set at push, wins over clear
      pe_q <= (pe_q && !clr) || (do_push && entry[9]);
      // [RULE16] noise only with pushed data
      nf_q <= (nf_q && !clr) || (do_push && entry[11]);
      // [RULE17] framing error
      fe_q <= (fe_q && !clr) || (do_push && entry[10]);
      // [RULE18] overflow flag
      oe_q <= (oe_q && !clr) || do_ovr;
      // [RULE20] trigger level, [RULE22] clears only when empty
      rxif_q <= cnt_n >= trig || (rxif_q && !(clr && rd_data && cnt_n == 3'h0));
      // [RULE7] last data bit one
      ahit_q <= (ahit_q && !rd_data) || (do_push && ctl2_q[`C2_ADDR_EN] && lastbit);
    end
  end

  // ========================================
  // Register reads, one cycle later
  // [RULE14] status read only, idle and empty read one at reset
  wire [7:0] status = {pe_q, nf_q, fe_q, oe_q, !rbusy_q, rxif_q, tidle, !tfull_q};
  reg [7:0] mux;
  always @* begin
    case (addr_in)
      `OFF_STATUS: mux = status;
      `OFF_CTL_ONE: mux = {en_q, bno_q, pren_q, prt_q, brk_q, head[8], 1'b0};
      `OFF_CTL_TWO: mux = ctl2_q;
      `OFF_DATA: mux = head[7:0];
      `OFF_BAUD_HIGH: mux = bdh_q;
      `OFF_BAUD_LOW: mux = bdl_q;
      `OFF_FIFO_CTL: mux = {2'b00, fcr_q};
      `OFF_RX_COUNT: mux = {5'h00, cnt_q};
      default: mux = 8'h00;
    endcase
  end

  // Pins and interrupt, all registered
  always @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rd_data_out <= 8'h00;
      serial_out_pin_out <= 1'b1;
      serial_out_pin_oe_n_out <= 1'b1;
      tx_pullup_en_out <= 1'b1;
      irq_out <= 1'b0;
    end else begin
      rd_data_out <= rd_in ? mux : 8'h00;
      // [RULE23] line rests high when idle
      serial_out_pin_out <= tbusy_q ? tsh_q[0] : !tbrk_q;
      // [RULE9] drive and drop pull-up, [RULE10] float when off
      serial_out_pin_oe_n_out <= !txon;
      tx_pullup_en_out <= !txon;
      // [RULE8] interrupt sources
      irq_out <= (ctl2_q[`C2_RX_IE] && (rxif_q || oe_q))
        || (ctl2_q[`C2_TIDLE_IE] && tidle && txon)
        || (ctl2_q[`C2_TEMPTY_IE] && !tfull_q && txon)
        || ahit_q;
    end
  end

endmodule // async_serial_port

/* bench/serial_port_checker_asserts.sv */
/*
  Port-level checker for the serial port, bound to its top module.
  Assumes the register map header and a divider of zero or more.
*/
`timescale 1ns/100ps
`include "serial_port_map.vh"
module serial_port_checker #(
  parameter FIFO_DEPTH = 4
) (
  input wire clock_in,
  input wire reset_n_in,
  input wire [2:0] addr_in,
  input wire [7:0] wr_data_in,
  input wire wr_in,
  input wire rd_in,
  input wire [7:0] rd_data_out,
  input wire serial_in_pin_in,
  input wire serial_out_pin_out,
  input wire serial_out_pin_oe_n_out,
  input wire tx_pullup_en_out,
  input wire irq_out
);
  // ========================================
  // Register port and pin relations
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);
  // Read data shows only in the cycle after a read strobe
  AST_RD_IDLE_ZERO: assert property (!rd_in |=> rd_data_out == 8'h00)
    else $error("read data not zero");
  // Pull-up is allowed exactly while the pin floats
  AST_PULLUP_MIRRORS: assert property (tx_pullup_en_out == serial_out_pin_oe_n_out)
    else $error("pull-up against drive");
  // A bit lasts at least 16 ticks, so no level change for 8 clocks
  AST_BIT_HOLD: assert property ($changed(serial_out_pin_out) && !serial_out_pin_oe_n_out
    |=> ($stable(serial_out_pin_out) || serial_out_pin_oe_n_out) [*8])
    else $error("serial bit too short");
  AST_TIDLE_NEEDS_EMPTY: assert property (rd_in && addr_in == `OFF_STATUS
    |=> !rd_data_out[1] || rd_data_out[0])
    else $error("idle without empty buffer");
  AST_TIDLE_LINE_HIGH: assert property (rd_in && addr_in == `OFF_STATUS
    ##1 rd_data_out[1] |-> serial_out_pin_out)
    else $error("idle but line low");
  AST_COUNT_MAX: assert property (rd_in && addr_in == `OFF_RX_COUNT
    |=> rd_data_out <= 8'h04)
    else $error("count above four");
  AST_TX8_READS_ZERO: assert property (rd_in && addr_in == `OFF_CTL_ONE
    |=> !rd_data_out[`C1_TX8])
    else $error("ninth transmit bit readable");
  // Both registered from en_q: the float shows in the same cycle as the read data
  AST_PORT_OFF_FLOATS: assert property (rd_in && addr_in == `OFF_CTL_ONE
    ##1 !rd_data_out[`C1_PORT_EN] |=> serial_out_pin_oe_n_out)
    else $error("pin driven with port off");
  COV_QUEUE_FULL: cover property (rd_in && addr_in == `OFF_RX_COUNT ##1 rd_data_out == 8'h04);
  COV_OVERRUN: cover property (rd_in && addr_in == `OFF_STATUS ##1 rd_data_out[4]);
  COV_IRQ: cover property ($rose(irq_out));
endmodule // serial_port_checker

bind async_serial_port serial_port_checker #(.FIFO_DEPTH(FIFO_DEPTH)) chk_u (
  .clock_in(clock_in), .reset_n_in(reset_n_in), .addr_in(addr_in),
  .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out),
  .serial_in_pin_in(serial_in_pin_in), .serial_out_pin_out(serial_out_pin_out),
  .serial_out_pin_oe_n_out(serial_out_pin_oe_n_out),
  .tx_pullup_en_out(tx_pullup_en_out), .irq_out(irq_out));

/* bench/serial_far_end.sv */
/*
  Far-end serial device: sends frames onto the receive pin and
  collects eight-bit characters from the transmit line.
  Assumes the bench's bit length in clocks.
*/
`timescale 1ns/100ps
module serial_far_end #(
  parameter int BIT = 16
) (
  input wire clock_in,
  input wire line_in,
  output logic line_out
);
  logic [7:0] got_q [$];
  logic [7:0] sh;
  initial line_out = 1'b1;
  // ========================================
  // Frame sender, one idle bit after each frame
  // LSB first, idle high
  task send(input [8:0] v, input int n, input logic stop_lvl);
    @(posedge clock_in);
    line_out <= 1'b0;
    repeat (BIT) @(posedge clock_in);
    for (int i = 0; i < n; i++) begin
      line_out <= v[i];
      repeat (BIT) @(posedge clock_in);
    end
    line_out <= stop_lvl;
    repeat (BIT) @(posedge clock_in);
    line_out <= 1'b1;
    repeat (BIT) @(posedge clock_in);
  endtask
  // ========================================
  // Collector, sampling at bit centres
  // LSB first
  always begin
    @(negedge line_in);
    repeat (BIT / 2) @(posedge clock_in);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge clock_in);
      sh[i] = line_in;
    end
    repeat (BIT) @(posedge clock_in);
    got_q.push_back(sh);
  end
endmodule // serial_far_end

/* bench/async_serial_port_status_tb_top.sv */
/*
  Self-checking bench: register access, transmit, receive queue,
  errors, parity types and port disable.
  Assumes divider zero, so one serial bit lasts 16 clocks.
*/
`timescale 1ns/100ps
`include "serial_port_map.vh"
module async_serial_port_status_tb_top;
  logic clock_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [2:0] addr_in = 3'h0;
  logic [7:0] wr_data_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [7:0] rd_data_out;
  logic serial_in_pin_in;
  logic serial_out_pin_out;
  logic serial_out_pin_oe_n_out;
  logic tx_pullup_en_out;
  logic irq_out;
  wire tx_line;
  int err_count = 0;
  int compares = 0;
  // ========================================
  // Clock, device and far end
  always #12.5 clock_in = ~clock_in;
  async_serial_port #(.FIFO_DEPTH(4)) dut_u (.clock_in(clock_in), .reset_n_in(reset_n_in),
    .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in),
    .rd_data_out(rd_data_out), .serial_in_pin_in(serial_in_pin_in),
    .serial_out_pin_out(serial_out_pin_out), .serial_out_pin_oe_n_out(serial_out_pin_oe_n_out),
    .tx_pullup_en_out(tx_pullup_en_out), .irq_out(irq_out));
  // A floating transmit pin rests on its pull-up
  assign tx_line = serial_out_pin_oe_n_out ? 1'b1 : serial_out_pin_out;
  serial_far_end #(.BIT(16)) far_u (.clock_in(clock_in), .line_in(tx_line),
    .line_out(serial_in_pin_in));
  // ========================================
  // Access and compare tasks
  task summarize;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task check(input string n, input [7:0] e, input [7:0] g);
    compares++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", n, e, g);
      err_count++;
    end
  endtask
  task wr(input [2:0] a, input [7:0] d);
    @(posedge clock_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wr_data_in <= d;
    @(posedge clock_in);
    wr_in <= 1'b0;
  endtask
  // Read data is taken just after the edge that registers it
  task rd(input [2:0] a, input [7:0] e, input string n);
    @(posedge clock_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clock_in);
    rd_in <= 1'b0;
    #1 check(n, e, rd_data_out);
  endtask
  // Bounded wait for characters at the far end
  task wait_far(input int n);
    int i;
    for (i = 0; i < 4000 && far_u.got_q.size() < n; i++) @(posedge clock_in);
    if (i == 4000) begin
      err_count++;
      $display("BAD far_count expected %0d seen %0d", n, far_u.got_q.size());
      summarize();
    end
  endtask
  // ========================================
  // Main sequence
  initial begin
    repeat (10) @(posedge clock_in);
    reset_n_in <= 1'b1;
    rd(`OFF_STATUS, `STATUS_RST, "status_reset");
    wr(`OFF_STATUS, 8'hF0);
    rd(`OFF_STATUS, `STATUS_RST, "status_ro");
    wr(`OFF_CTL_TWO, 8'hC0);
    rd(`OFF_CTL_TWO, `CTL_RST, "enables_port_off");
    check("oe_n_off", 8'h01, {7'h00, serial_out_pin_oe_n_out});
    wr(`OFF_BAUD_HIGH, 8'h12);
    rd(`OFF_BAUD_HIGH, 8'h12, "baud_high");
    wr(`OFF_BAUD_HIGH, 8'h00);
    wr(`OFF_BAUD_LOW, 8'h00);
    wr(`OFF_CTL_ONE, 8'h80);
    wr(`OFF_CTL_TWO, 8'hC4);
    repeat (2) @(posedge clock_in);
    #1 check("oe_n_on", 8'h00, {7'h00, serial_out_pin_oe_n_out});
    check("pullup_on", 8'h00, {7'h00, tx_pullup_en_out});
    // One character shifting, one pending
    wr(`OFF_DATA, 8'hA5);
    wr(`OFF_DATA, 8'h3C);
    wait_far(2);
    check("tx_first", 8'hA5, far_u.got_q[0]);
    check("tx_second", 8'h3C, far_u.got_q[1]);
    repeat (40) @(posedge clock_in);
    rd(`OFF_STATUS, 8'h0B, "status_tx_done");
    check("irq_quiet", 8'h00, {7'h00, irq_out});
    // Fill the queue, then one frame more to overrun
    far_u.send(9'h010, 8, 1'b1);
    repeat (4) @(posedge clock_in);
    #1 check("irq_rx", 8'h01, {7'h00, irq_out});
    for (int i = 1; i < 5; i++) far_u.send({1'b0, 8'h10 + 8'(i)}, 8, 1'b1);
    repeat (4) @(posedge clock_in);
    rd(`OFF_RX_COUNT, 8'h04, "rx_count_full");
    for (int i = 0; i < 4; i++) begin
      rd(`OFF_STATUS, (i == 0) ? 8'h1F : 8'h0F, "status_rx");
      rd(`OFF_DATA, 8'h10 + 8'(i), "rx_data");
    end
    rd(`OFF_STATUS, 8'h0B, "status_drained");
    // Stop bit held low
    far_u.send(9'h055, 8, 1'b0);
    rd(`OFF_STATUS, 8'h2F, "status_framing");
    rd(`OFF_DATA, 8'h55, "rx_framing");
    // Even parity with a wrong parity bit
    wr(`OFF_CTL_ONE, 8'hA0);
    far_u.send(9'h001, 8, 1'b1);
    rd(`OFF_STATUS, 8'h8F, "status_parity");
    rd(`OFF_DATA, 8'h01, "rx_parity");
    // Every parity type with a correct parity bit
    for (int t = 0; t < 4; t++) begin
      wr(`OFF_CTL_ONE, 8'hA0 | 8'(t << 3));
      far_u.send({1'b0, ~t[0], 7'h01}, 8, 1'b1);
      rd(`OFF_STATUS, 8'h0F, "status_type");
      rd(`OFF_DATA, 8'h01, "rx_type");
    end
    // Nine data bits, two stop bits, address detect without receive interrupt
    wr(`OFF_CTL_ONE, 8'hC0);
    wr(`OFF_CTL_TWO, 8'hF0);
    far_u.send(9'h1AB, 9, 1'b1);
    rd(`OFF_CTL_ONE, 8'hC2, "ninth_bit");
    check("irq_addr", 8'h01, {7'h00, irq_out});
    rd(`OFF_STATUS, 8'h0F, "status_nine");
    rd(`OFF_DATA, 8'hAB, "rx_nine");
    rd(`OFF_RX_COUNT, 8'h00, "count_nine");
    check("irq_addr_clear", 8'h00, {7'h00, irq_out});
    wr(`OFF_CTL_ONE, 8'h80);
    wr(`OFF_CTL_TWO, 8'hC4);
    // Disable with a character still queued
    far_u.send(9'h077, 8, 1'b1);
    wr(`OFF_CTL_ONE, 8'h00);
    rd(`OFF_RX_COUNT, 8'h00, "count_flushed");
    rd(`OFF_STATUS, `STATUS_RST, "status_off");
    rd(`OFF_CTL_TWO, 8'h04, "ctl_two_off");
    summarize();
  end
endmodule // async_serial_port_status_tb_top
